// ==== precision_reference_timing_tb.sv ====
`timescale 1ns/1ps
module precision_reference_timing_tb;
	logic mclk_in, rst_in, rd, wr, wreq, xtal, vco, ret, rp, sp, pol, r16, r8, rcyc;
	logic lclk, ldat, lload, eref, pcu, pcd;
	logic [4:0] addr, cap;
	logic [31:0] wd, rdata, q, seed;
	logic [7:0] astat, rb;
	logic [47:0] latch, w;
	logic [3:0] qs, rms;
	int err_count, comparisons, ncyc, npulse, k;
	int ratios[3] = '{1, 10, 100};
	int edges[3] = '{205, 237, 1350};
	logic [15:0] nv[8] = '{16'h0000, 16'h00FF, 16'h0100, 16'h03FF, 16'h0400, 16'h1000,
		16'h4000, 16'hFFFF};

	prt_core u_prt_core (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.xtal_in(xtal), .ext_ref_in(eref), .vco_in(vco), .link_clk_in(lclk),
		.link_data_in(ldat), .link_load_in(lload), .astat_in(astat), .latch_out(latch),
		.link_ret_out(ret), .reset_pulse_out(rp), .set_pulse_out(sp), .pol_neg_out(pol),
		.ref16_out(r16), .ref8_out(r8), .pc_up_out(pcu), .pc_dn_out(pcd), .cap_sel_out(cap),
		.qs_tap_out(qs), .rms_step_out(rms), .rms_cycle_out(rcyc));

	prt_host_link u_prt_host_link (.mclk_in(mclk_in), .ret_in(ret), .clk_out(lclk),
		.data_out(ldat), .load_out(lload));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [4:0] band(logic [15:0] n);
		if (n >= prt_pkg::BAND_T4) return 5'h10;
		if (n >= prt_pkg::BAND_T3) return 5'h08;
		if (n >= prt_pkg::BAND_T2) return 5'h04;
		if (n >= prt_pkg::BAND_T1) return 5'h02;
		return 5'h01;
	endfunction

	// The half-rate reference toggles on every rising edge of the 16 kHz tap.
	function automatic logic r8x(int t);
		if (t < 128) return 1'b0;
		return 1'(((t - 128) / 256 + 1) % 2);
	endfunction

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [47:0] s, input logic [47:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic av(input logic w_en, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_in);
		rd <= ~w_en;
		wr <= w_en;
		addr <= a;
		wd <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk_in);
			if (wreq === 1'b0) break;
		end
		if (n == 20) begin
			err_count++;
			finish_test();
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Pulses the crystal (sel 0), oscillator (sel 1) or external reference (sel 2) pin n times.
	task automatic pins(input int sel, input int n);
		repeat (n) begin
			@(posedge mclk_in);
			if (sel == 0) xtal <= 1'b1;
			else if (sel == 1) vco <= 1'b1;
			else eref <= 1'b1;
			repeat (6) @(posedge mclk_in);
			xtal <= 1'b0;
			vco <= 1'b0;
			eref <= 1'b0;
			repeat (5) @(posedge mclk_in);
		end
		repeat (8) @(posedge mclk_in);
	endtask

	task automatic reset_dut();
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	always @(posedge mclk_in) begin
		if (rcyc === 1'b1) ncyc++;
		if (rp === 1'b1 || sp === 1'b1) npulse++;
	end

	initial begin
		{rst_in, rd, wr, xtal, vco} = 5'h10;
		addr = 5'h00;
		wd = 32'h00000000;
		astat = 8'h00;
		eref = 1'b0;
		seed = 32'hC7F7FBFF;
		repeat (2) @(posedge mclk_in);
		chk(wreq, 1'b1);
		chk({qs, rms, r16, pol}, 10'h000);
		rst_in <= 1'b0;
		av(1'b0, prt_pkg::A_CNT, 32'h0);
		chk(q, 32'h0);
		for (k = 0; k < 8; k++) begin
			av(1'b1, prt_pkg::A_CTRL, 32'(k));
			repeat (3) @(posedge mclk_in);
			chk(pol, k[1] & ~k[0]);
		end
		w[31:0] = rnd();
		av(1'b1, prt_pkg::A_CMP, {7'h00, w[24:0]});
		av(1'b0, prt_pkg::A_CMP, 32'h0);
		chk(q, {7'h00, w[24:0]});
		nv[7] = 16'(rnd());
		for (k = 0; k < 8; k++) begin
			av(1'b1, prt_pkg::A_NWORD, {16'h0000, nv[k]});
			repeat (3) @(posedge mclk_in);
			chk(cap, band(nv[k]));
		end
		av(1'b1, prt_pkg::A_CTRL, 32'h1);
		k = 300 + int'(rnd() % 32'd400);
		pins(0, k);
		av(1'b0, prt_pkg::A_CNT, 32'h0);
		chk(q, 32'(k));
		av(1'b0, prt_pkg::A_STAT, 32'h0);
		chk(q[29:17], 13'(k));
		chk(r16, k[7]);
		chk(r8, r8x(k));
		chk(npulse, 0);
		chk({pcu, pcd}, 2'b10);
		av(1'b1, prt_pkg::A_CTRL, 32'h5);
		pins(2, 1);
		k = 20 + int'(rnd() % 32'd100);
		pins(0, k);
		av(1'b0, prt_pkg::A_STAT, 32'h0);
		chk(q[29:17], 13'(k));
		q = rnd();
		w[47:32] = q[15:0];
		w[31:0] = rnd();
		astat <= q[23:16];
		u_prt_host_link.send(w, rb);
		repeat (8) @(posedge mclk_in);
		chk(latch, w);
		av(1'b0, prt_pkg::A_LATLO, 32'h0);
		chk(q, w[31:0]);
		av(1'b0, prt_pkg::A_LATHI, 32'h0);
		chk(q[15:0], w[47:32]);
		u_prt_host_link.send(~w, rb);
		chk(rb, astat);
		for (k = 0; k < 3; k++) begin
			reset_dut();
			ncyc = 0;
			av(1'b1, prt_pkg::A_RANGE, 32'(k));
			pins(1, edges[k]);
			chk(qs, (edges[k] / ratios[k]) % 10);
			chk(rms, (edges[k] / ratios[k] / 10) % 10);
			chk(ncyc, edges[k] / ratios[k] / 100);
			chk({pcu, pcd}, 2'b01);
		end
		finish_test();
	end
endmodule

// ==== prt_core.sv ====
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module prt_core (
	// Clock and reset.
	input logic mclk_in,
	input logic rst_in,
	// Avalon-MM register slave.
	input logic [prt_pkg::AW-1:0] avs_address_in,
	input logic avs_read_in,
	input logic avs_write_in,
	input logic [31:0] avs_writedata_in,
	input logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Clock-like pins from the analog side.
	input logic xtal_in,
	input logic ext_ref_in,
	input logic vco_in,
	// Serial link and analog status.
	input logic link_clk_in,
	input logic link_data_in,
	input logic link_load_in,
	input logic [prt_pkg::STAT_W-1:0] astat_in,
	output logic [prt_pkg::LATCH_W-1:0] latch_out,
	output logic link_ret_out,
	// Reference switching.
	output logic reset_pulse_out,
	output logic set_pulse_out,
	output logic pol_neg_out,
	// Synthesizer.
	output logic ref16_out,
	output logic ref8_out,
	output logic pc_up_out,
	output logic pc_dn_out,
	output logic [prt_pkg::BANDS-1:0] cap_sel_out,
	// Quasi-sine and RMS sequencing.
	output logic [3:0] qs_tap_out,
	output logic [3:0] rms_step_out,
	output logic rms_cycle_out
);
	typedef struct packed {
		logic [2:0] s0;
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] f;
		logic [2:0] ctrl;
		logic [prt_pkg::CNT_W-1:0] cmp_pend;
		logic [prt_pkg::CNT_W-1:0] cmp_act;
		logic [prt_pkg::CNT_W-1:0] cnt;
		logic run;
		logic rst_p;
		logic set_p;
		logic [prt_pkg::REF_W-1:0] rcnt;
		logic ref16;
		logic ref8;
		logic [prt_pkg::N_W-1:0] nw;
		logic [2:0] rng;
		logic [prt_pkg::N_W-1:0] ndiv;
		logic up;
		logic dn;
		logic [prt_pkg::RDIV_W-1:0] rdiv;
		logic [3:0] qs;
		logic [3:0] rms;
		logic rms_cyc;
		logic [prt_pkg::BANDS-1:0] cap;
		logic pol;
		logic wreq;
		logic [31:0] rdata;
	} prt_state_t;

	prt_state_t q;
	prt_state_t d;
	logic xt;
	logic er;
	logic vr;
	logic fb;
	logic rt;

	prt_link_if lk ();

	prt_link u_link (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.link_clk_in(link_clk_in),
		.link_data_in(link_data_in),
		.link_load_in(link_load_in),
		.astat_in(astat_in),
		.lk(lk)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [prt_pkg::RDIV_W-1:0] range_ratio(input logic [2:0] code);
		logic [prt_pkg::RDIV_W-1:0] r;
		case (code)
			3'h0: r = prt_pkg::RATIO_0;
			3'h1: r = prt_pkg::RATIO_1;
			3'h2: r = prt_pkg::RATIO_2;
			3'h3: r = prt_pkg::RATIO_3;
			default: r = prt_pkg::RATIO_4;
		endcase
		return r;
	endfunction

	function automatic logic [prt_pkg::BANDS-1:0] band_sel(input logic [prt_pkg::N_W-1:0] n);
		logic [prt_pkg::BANDS-1:0] r;
		r = '0;
		if (n >= prt_pkg::BAND_T4) begin
			r[4] = 1'b1;
		end else if (n >= prt_pkg::BAND_T3) begin
			r[3] = 1'b1;
		end else if (n >= prt_pkg::BAND_T2) begin
			r[2] = 1'b1;
		end else if (n >= prt_pkg::BAND_T1) begin
			r[1] = 1'b1;
		end else begin
			r[0] = 1'b1;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [prt_pkg::N_W:0] ninc;
		logic [prt_pkg::RDIV_W-1:0] rinc;
		logic [31:0] rv;
		logic [31:0] wv;
		ninc = '0;
		rinc = '0;
		rv = '0;
		wv = '0;
		d = q;
		d.s0 = {vco_in, ext_ref_in, xtal_in};
		d.s1 = q.s0;
		d.s2 = q.s1;
		d.f = (q.s1 & q.s2) | (q.f & (q.s1 | q.s2));
		xt = d.f[prt_pkg::PIN_XTAL] & ~q.f[prt_pkg::PIN_XTAL];
		er = d.f[prt_pkg::PIN_EXT] & ~q.f[prt_pkg::PIN_EXT];
		vr = d.f[prt_pkg::PIN_VCO] & ~q.f[prt_pkg::PIN_VCO];

		// Period division counter and switching pulses.
		d.rst_p = 1'b0;
		d.set_p = 1'b0;
		if (xt) begin
			d.cnt = q.cnt + prt_pkg::CNT_ONE;
			d.rst_p = q.run && (q.cnt == q.cmp_act);
			if (q.cnt == prt_pkg::CNT_MAX) begin
				d.set_p = 1'b1;
				d.cmp_act = q.cmp_pend;
				d.run = 1'b1;
			end
		end

		// Frequency reference.
		if (xt) begin
			d.rcnt = q.rcnt + prt_pkg::REF_ONE;
		end
		if (q.ctrl[prt_pkg::CTRL_EXT] && er) begin
			d.rcnt = '0;
		end
		d.ref16 = q.ctrl[prt_pkg::CTRL_AC] & q.rcnt[prt_pkg::REF_TAP];
		if (d.ref16 && !q.ref16) begin
			d.ref8 = ~q.ref8;
		end

		// Divide by n and phase-frequency compare.
		fb = 1'b0;
		if (vr) begin
			ninc = {1'b0, q.ndiv} + {{prt_pkg::N_W{1'b0}}, 1'b1};
			if (ninc >= {1'b0, q.nw}) begin
				d.ndiv = '0;
				fb = 1'b1;
			end else begin
				d.ndiv = ninc[prt_pkg::N_W-1:0];
			end
		end
		d.up = q.up | (d.ref8 & ~q.ref8);
		d.dn = q.dn | fb;
		if (d.up && d.dn) begin
			d.up = 1'b0;
			d.dn = 1'b0;
		end
		d.cap = band_sel(q.nw);

		// Range divider chain ending in the quasi-sine and RMS decades.
		rt = 1'b0;
		if (vr) begin
			rinc = q.rdiv + prt_pkg::RDIV_ONE;
			if (rinc >= range_ratio(q.rng)) begin
				d.rdiv = '0;
				rt = 1'b1;
			end else begin
				d.rdiv = rinc;
			end
		end
		d.rms_cyc = 1'b0;
		if (rt) begin
			if (q.qs == prt_pkg::STEP_LAST) begin
				d.qs = '0;
				if (q.rms == prt_pkg::STEP_LAST) begin
					d.rms = '0;
					d.rms_cyc = 1'b1;
				end else begin
					d.rms = q.rms + prt_pkg::STEP_ONE;
				end
			end else begin
				d.qs = q.qs + prt_pkg::STEP_ONE;
			end
		end
		d.pol = q.ctrl[prt_pkg::CTRL_NEG] & ~q.ctrl[prt_pkg::CTRL_AC];

		// Register slave: one wait cycle, then the access completes.
		if ((avs_read_in || avs_write_in) && q.wreq) begin
			d.wreq = 1'b0;
			if (avs_address_in == prt_pkg::A_CTRL) begin
				rv = {29'h0, q.ctrl};
			end else if (avs_address_in == prt_pkg::A_CMP) begin
				rv = {7'h0, q.cmp_pend};
			end else if (avs_address_in == prt_pkg::A_NWORD) begin
				rv = {16'h0, q.nw};
			end else if (avs_address_in == prt_pkg::A_RANGE) begin
				rv = {29'h0, q.rng};
			end else if (avs_address_in == prt_pkg::A_STAT) begin
				rv[prt_pkg::ST_RUN] = q.run;
				rv[prt_pkg::ST_QS +: 4] = q.qs;
				rv[prt_pkg::ST_RMS +: 4] = q.rms;
				rv[prt_pkg::ST_LINK +: prt_pkg::STAT_W] = lk.stat;
				rv[prt_pkg::ST_REF +: prt_pkg::REF_W] = q.rcnt;
			end else if (avs_address_in == prt_pkg::A_CNT) begin
				rv = {7'h0, q.cnt};
			end else if (avs_address_in == prt_pkg::A_LATLO) begin
				rv = lk.latch[31:0];
			end else if (avs_address_in == prt_pkg::A_LATHI) begin
				rv = {16'h0, lk.latch[prt_pkg::LATCH_W-1:32]};
			end else begin
				rv = '0;
			end
			d.rdata = avs_read_in ? rv : q.rdata;
		end else if (avs_write_in) begin
			d.wreq = 1'b1;
			if (avs_address_in == prt_pkg::A_CTRL) begin
				wv = be_merge({29'h0, q.ctrl}, avs_writedata_in, avs_byteenable_in);
				d.ctrl = wv[2:0];
			end else if (avs_address_in == prt_pkg::A_CMP) begin
				wv = be_merge({7'h0, q.cmp_pend}, avs_writedata_in, avs_byteenable_in);
				d.cmp_pend = wv[prt_pkg::CNT_W-1:0];
			end else if (avs_address_in == prt_pkg::A_NWORD) begin
				wv = be_merge({16'h0, q.nw}, avs_writedata_in, avs_byteenable_in);
				d.nw = wv[prt_pkg::N_W-1:0];
			end else if (avs_address_in == prt_pkg::A_RANGE) begin
				wv = be_merge({29'h0, q.rng}, avs_writedata_in, avs_byteenable_in);
				d.rng = wv[2:0];
			end
		end else begin
			d.wreq = 1'b1;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			q <= '0;
			q.wreq <= 1'b1;
			q.nw <= prt_pkg::N_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign avs_readdata_out = q.rdata;
	assign avs_waitrequest_out = q.wreq;
	assign latch_out = lk.latch;
	assign link_ret_out = lk.ret;
	assign reset_pulse_out = q.rst_p;
	assign set_pulse_out = q.set_p;
	assign pol_neg_out = q.pol;
	assign ref16_out = q.ref16;
	assign ref8_out = q.ref8;
	assign pc_up_out = q.up;
	assign pc_dn_out = q.dn;
	assign cap_sel_out = q.cap;
	assign qs_tap_out = q.qs;
	assign rms_step_out = q.rms;
	assign rms_cycle_out = q.rms_cyc;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	sequence match_s;
		xt && q.run && (q.cnt == q.cmp_act);
	endsequence
	sequence ovf_s;
		xt && (q.cnt == prt_pkg::CNT_MAX);
	endsequence
	sequence qs_wrap_s;
		rt && (q.qs == prt_pkg::STEP_LAST);
	endsequence

	cnt_step_a: assert property (xt |=> q.cnt == $past(q.cnt) + prt_pkg::CNT_ONE)
		else $error("counter did not advance on crystal tick");
	cmp_load_a: assert property (ovf_s |=> q.cmp_act == $past(q.cmp_pend))
		else $error("comparison value not loaded at overflow");
	cmp_hold_a: assert property (!(xt && q.cnt == prt_pkg::CNT_MAX) |=> $stable(q.cmp_act))
		else $error("comparison value changed away from overflow");
	reset_pulse_a: assert property (match_s |=> reset_pulse_out ##1 !reset_pulse_out)
		else $error("reset pulse missing or too long");
	quiet_start_a: assert property (!q.run |-> !reset_pulse_out)
		else $error("reset pulse before first period");
	set_pulse_a: assert property (ovf_s |=> set_pulse_out && q.cnt == '0)
		else $error("set pulse missing at overflow");
	pol_sel_a: assert property (1'b1 |=>
		pol_neg_out == $past(q.ctrl[prt_pkg::CTRL_NEG] && !q.ctrl[prt_pkg::CTRL_AC]))
		else $error("polarity select wrong");
	qs_wrap_a: assert property (qs_wrap_s |=> q.qs == '0)
		else $error("quasi-sine step did not wrap after ten");
	rms_adv_a: assert property (qs_wrap_s ##0 q.rms != prt_pkg::STEP_LAST |=>
		q.rms == $past(q.rms) + prt_pkg::STEP_ONE)
		else $error("rms step did not follow quasi-sine period");
	rms_cycle_a: assert property (qs_wrap_s ##0 q.rms == prt_pkg::STEP_LAST |=>
		rms_cycle_out && q.rms == '0)
		else $error("rms cycle did not close after ten periods");
	ref_half_a: assert property ($rose(ref16_out) |-> ref8_out != $past(ref8_out))
		else $error("8 kHz reference did not toggle");
	ext_lock_a: assert property (q.ctrl[prt_pkg::CTRL_EXT] && er |=> q.rcnt == '0)
		else $error("reference not aligned to external edge");
endmodule

// ==== prt_host_link.sv ====
`timescale 1ns/1ps
module prt_host_link (
	// Clock.
	input wire logic mclk_in,
	// Returned status bit.
	input wire logic ret_in,
	// Link pins driven by the processor side.
	output logic clk_out,
	output logic data_out,
	output logic load_out
);
	initial begin
		clk_out = 1'b0;
		data_out = 1'b0;
		load_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One frame: 48 bits msb first, then a load strobe. The link clock stands
	// still between frames, and the data line shows the inverse of its last bit.
	task automatic send(input logic [47:0] w, output logic [7:0] ret);
		for (int i = 47; i >= 0; i--) begin
			@(posedge mclk_in);
			data_out <= w[i];
			repeat (4) @(posedge mclk_in);
			clk_out <= 1'b1;
			repeat (8) @(posedge mclk_in);
			if (i > 39) ret[i-40] = ret_in;
			clk_out <= 1'b0;
		end
		repeat (4) @(posedge mclk_in);
		data_out <= ~w[0];
		load_out <= 1'b1;
		repeat (8) @(posedge mclk_in);
		load_out <= 1'b0;
		repeat (8) @(posedge mclk_in);
	endtask
endmodule

// ==== prt_link.sv ====
`timescale 1ns/1ps
module prt_link (
	// Clock and reset.
	input logic mclk_in,
	input logic rst_in,
	// Serial link pins and analog status.
	input logic link_clk_in,
	input logic link_data_in,
	input logic link_load_in,
	input logic [prt_pkg::STAT_W-1:0] astat_in,
	// Latch contents and returned status.
	prt_link_if.link lk
);
	localparam int SW = prt_pkg::STAT_W + 3;

	typedef struct packed {
		logic [SW-1:0] s0;
		logic [SW-1:0] s1;
		logic [SW-1:0] s2;
		logic [SW-1:0] f;
		logic [prt_pkg::LATCH_W-1:0] sh;
		logic [prt_pkg::LATCH_W-1:0] lat;
		logic [prt_pkg::STAT_W-1:0] rsh;
		logic ret;
	} prt_link_st_t;

	prt_link_st_t q;
	prt_link_st_t d;
	logic cr;
	logic ld;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.s0 = {astat_in, link_load_in, link_data_in, link_clk_in};
		d.s1 = q.s0;
		d.s2 = q.s1;
		// A change counts once the second and third stages agree.
		d.f = (q.s1 & q.s2) | (q.f & (q.s1 | q.s2));
		cr = d.f[0] & ~q.f[0];
		ld = d.f[2] & ~q.f[2];
		if (ld) begin
			d.lat = q.sh;
			d.rsh = q.f[SW-1:3];
		end else if (cr) begin
			d.sh = {q.sh[prt_pkg::LATCH_W-2:0], q.f[1]};
			d.ret = q.rsh[prt_pkg::STAT_W-1];
			d.rsh = {q.rsh[prt_pkg::STAT_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lk.latch = q.lat;
	assign lk.stat = q.f[SW-1:3];
	assign lk.ret = q.ret;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	latch_load_a: assert property (ld |=> lk.latch == $past(q.sh))
		else $error("control latch not loaded from shift register");
	ret_shift_a: assert property (cr && !ld |=> lk.ret == $past(q.rsh[prt_pkg::STAT_W-1]))
		else $error("status bit not returned on link clock");
endmodule

// ==== prt_link_if.sv ====
`timescale 1ns/1ps
interface prt_link_if;
	logic [prt_pkg::LATCH_W-1:0] latch;
	logic [prt_pkg::STAT_W-1:0] stat;
	logic ret;
	modport link(output latch, output stat, output ret);
	modport core(input latch, input stat, input ret);
endinterface

// ==== prt_pkg.sv ====
package prt_pkg;
	localparam int CNT_W = 25;
	localparam logic [CNT_W-1:0] CNT_MAX = 25'h1FFFFFF;
	localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;
	localparam int REF_W = 13;
	// Crystal divided by 2^(REF_TAP+1) gives the 16 kHz reference.
	localparam int REF_TAP = 7;
	localparam logic [REF_W-1:0] REF_ONE = 13'h0001;
	localparam int N_W = 16;
	localparam logic [N_W-1:0] N_RST = 16'h0001;
	localparam logic [N_W-1:0] BAND_T1 = 16'h0100;
	localparam logic [N_W-1:0] BAND_T2 = 16'h0400;
	localparam logic [N_W-1:0] BAND_T3 = 16'h1000;
	localparam logic [N_W-1:0] BAND_T4 = 16'h4000;
	localparam int BANDS = 5;
	localparam int RDIV_W = 14;
	localparam logic [RDIV_W-1:0] RDIV_ONE = 14'h0001;
	localparam logic [RDIV_W-1:0] RATIO_0 = 14'h0001;
	localparam logic [RDIV_W-1:0] RATIO_1 = 14'h000A;
	localparam logic [RDIV_W-1:0] RATIO_2 = 14'h0064;
	localparam logic [RDIV_W-1:0] RATIO_3 = 14'h03E8;
	localparam logic [RDIV_W-1:0] RATIO_4 = 14'h2710;
	localparam logic [3:0] STEP_LAST = 4'h9;
	localparam logic [3:0] STEP_ONE = 4'h1;
	localparam int LATCH_W = 48;
	localparam int STAT_W = 8;
	localparam int AW = 5;
	localparam logic [AW-1:0] A_CTRL = 5'h00;
	localparam logic [AW-1:0] A_CMP = 5'h04;
	localparam logic [AW-1:0] A_NWORD = 5'h08;
	localparam logic [AW-1:0] A_RANGE = 5'h0C;
	localparam logic [AW-1:0] A_STAT = 5'h10;
	localparam logic [AW-1:0] A_CNT = 5'h14;
	localparam logic [AW-1:0] A_LATLO = 5'h18;
	localparam logic [AW-1:0] A_LATHI = 5'h1C;
	localparam int CTRL_AC = 0;
	localparam int CTRL_NEG = 1;
	localparam int CTRL_EXT = 2;
	localparam int ST_RUN = 0;
	localparam int ST_QS = 1;
	localparam int ST_RMS = 5;
	localparam int ST_LINK = 9;
	localparam int ST_REF = 17;
	localparam int PIN_XTAL = 0;
	localparam int PIN_EXT = 1;
	localparam int PIN_VCO = 2;
endpackage
